// ### design/mcr_top.sv
/*
 * Machine-check register set: capability, global status and enable,
 * error banks, legacy capture, exception and shutdown outputs.
 * Assumes a register port driven by the core on clk_sys, one request a cycle.
 */
// Functional notes
// - Legacy scheme captures type, address, then exception
// - Legacy reports read parity and bus failures
// - Capability read-only, low byte gives bank count
// - Capability bit 8 flags global enable
// - Capability bit 9 flags extended registers
// - Capability bit 10 flags corrected counting
// - Bit 11 makes status 56:53 architectural
// - Capability 23:16 counts extended registers
// - Global bit 0 restart pointer reliable
// - Global bit 1 pointer tied to error
// - Global bit 2 in progress, second: shutdown
// - Global enable: ones enable, zeros disable
// - Banks from 400H, count at 0179H
// - Control holds 64 per-error enables
// - Unimplemented enable bits ignore writes
// - Legacy controls accept only ones or zeros
// - Status cleared by zeros, ones fault
// - Without counting, 52:38 is other info
// - Status 15:0 holds architecture error code
// - Bit 63 set on log, software clears
// - Bit 62 set on overflow, software clears
// - Bit 61 flags uncorrected error
// - Counter 52:38 counts corrected, sticky overflow
`timescale 1ns/1ps
module mcr_top
	import mcr_pkg::*;
#(
	parameter bit GEN_P = 1'b1,
	parameter bit EXT_P = 1'b0,
	parameter bit CNT_P = 1'b1,
	parameter bit TES_P = 1'b1
)
(
	input  wire logic                clk_sys,
	input  wire logic                rstn,
	input  wire mcr_pkg::mcr_req_s   req,
	input  wire logic                strict_ctl,
	input  wire mcr_pkg::mcr_err_s   err,
	input  wire mcr_pkg::mcr_legacy_s lerr,
	output logic [63:0]              rdata,
	output logic                     rvalid,
	output logic                     gp_fault,
	output logic                     check_exception,
	output logic                     shutdown
);

	logic        rst_s1_reg;
	logic        rst_n;
	logic [63:0] gstat_reg;
	logic [63:0] gen_reg;
	logic        enabled;
	logic [63:0] cap_word;
	logic [63:0] ctl_q [MCR_BANKS];
	logic [63:0] sts_q [MCR_BANKS];
	logic [MCR_BANKS-1:0] ctl_we;
	logic [MCR_BANKS-1:0] sts_we;
	logic [MCR_BANKS-1:0] bank_fire;
	logic [1:0]  ltype;
	logic [31:0] laddr;
	logic        lfire;
	logic        mc_event;
	logic [63:0] rd_next;
	logic        gp_next;
	logic        ltype_rd;
	logic        rip_reg;
	logic        eip_reg;

	// Reset release through two flip-flops
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_s1_reg <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_n      <= rst_s1_reg;
		end
	end

	function automatic logic is_bank(input logic [11:0] a, input int i, input int off);
		is_bank = (a == 12'(MCR_ADR_BANK0 + 12'(4 * i + off)));
	endfunction

	assign cap_word = mcr_cap_word(GEN_P, EXT_P, CNT_P, TES_P);
	assign enabled  = !GEN_P || (gen_reg == MCR_ONES);
	assign ltype_rd = req.rd && req.addr == MCR_ADR_LTYPE;

	// Bank write decode; control index 0 at 400H, status at +1
	always_comb
	begin
		for (int i = 0; i < MCR_BANKS; i++)
		begin
			ctl_we[i] = req.wr && is_bank(req.addr, i, 0);
			sts_we[i] = req.wr && is_bank(req.addr, i, 1);
		end
	end

	for (genvar g = 0; g < MCR_BANKS; g++)
	begin : g_bank
		mcr_err_s be;
		always_comb
		begin
			be       = err;
			be.valid = err.valid && err.bank == 2'(g) && enabled;
		end
		mcr_bank #(
			.CNT_P (CNT_P),
			.TES_P (TES_P)
		) u_bank (
			.clk_sys    (clk_sys),
			.rst_n      (rst_n),
			.ctl_we     (ctl_we[g]),
			.sts_we     (sts_we[g]),
			.strict_ctl (strict_ctl),
			.wdata      (req.wdata),
			.err        (be),
			.ctl_reg    (ctl_q[g]),
			.sts_reg    (sts_q[g]),
			.fire       (bank_fire[g])
		);
	end

	mcr_legacy u_legacy (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.lerr     (lerr),
		.rd_type  (ltype_rd),
		.type_reg (ltype),
		.addr_reg (laddr),
		.fire     (lfire)
	);

	assign mc_event = (|bank_fire) || lfire;

	// Pointer flags travel with the error report into the exception cycle
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rip_reg <= 1'b0;
			eip_reg <= 1'b0;
		end
		else
		begin
			rip_reg <= err.valid && err.restart_ok;
			eip_reg <= err.valid && err.ptr_ok;
		end
	end

	// Global status: exception sets in-progress, software may write it
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			gstat_reg <= MCR_ZERO;
		else if (mc_event)
		begin
			gstat_reg[MCR_GS_INPROG]  <= 1'b1;
			gstat_reg[MCR_GS_RESTART] <= rip_reg && !lfire;
			gstat_reg[MCR_GS_ERRPTR]  <= eip_reg && !lfire;
		end
		else if (req.wr && req.addr == MCR_ADR_GSTAT)
			gstat_reg[2:0] <= req.wdata[2:0];
	end

	// Global enable; only the two defined patterns take effect
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			gen_reg <= MCR_GEN_RESET;
		else if (GEN_P && req.wr && req.addr == MCR_ADR_GEN
			&& (req.wdata == MCR_ONES || req.wdata == MCR_ZERO))
			gen_reg <= req.wdata;
	end

	// Exception pulse and shutdown on a second event while in progress
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			check_exception <= 1'b0;
			shutdown        <= 1'b0;
		end
		else
		begin
			check_exception <= mc_event && !gstat_reg[MCR_GS_INPROG];
			if (mc_event && gstat_reg[MCR_GS_INPROG])
				shutdown <= 1'b1;
		end
	end

	// Read mux and fault check
	always_comb
	begin
		rd_next = MCR_ZERO;
		gp_next = 1'b0;
		if (req.addr == MCR_ADR_CAP)
			rd_next = cap_word;
		else if (req.addr == MCR_ADR_GSTAT)
			rd_next = {61'h0, gstat_reg[2:0]};
		else if (req.addr == MCR_ADR_GEN && GEN_P)
			rd_next = gen_reg;
		else if (req.addr == MCR_ADR_LTYPE)
			rd_next = {62'h0, ltype};
		else if (req.addr == MCR_ADR_LADDR)
			rd_next = {32'h0, laddr};
		for (int i = 0; i < MCR_BANKS; i++)
		begin
			if (is_bank(req.addr, i, 0))
				rd_next = ctl_q[i];
			if (is_bank(req.addr, i, 1))
			begin
				rd_next = sts_q[i];
				if (!CNT_P)
					rd_next[MCR_ST_CNT_HI:MCR_ST_CNT_LO] = 15'h0;
			end
			if (sts_we[i] && req.wdata != MCR_ZERO)
				gp_next = 1'b1;
		end
		if (req.wr && req.addr == MCR_ADR_CAP)
			gp_next = 1'b0;
		if (!EXT_P && req.addr >= MCR_ADR_EXT0 && req.addr < MCR_ADR_GSTAT)
			rd_next = MCR_ZERO;
	end

	// Read data one clock after the request
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata    <= MCR_ZERO;
			rvalid   <= 1'b0;
			gp_fault <= 1'b0;
		end
		else
		begin
			rdata    <= req.rd ? rd_next : MCR_ZERO;
			rvalid   <= req.rd;
			gp_fault <= gp_next;
		end
	end

endmodule

// ### design/mcr_pkg.sv
/*
 * Package for the machine-check register set: register indices, capability
 * and status field positions, reset values and carrier structs.
 * Assumes a single core clock domain and 64-bit register data.
 */
package mcr_pkg;

	localparam int          MCR_BANKS       = 4;
	localparam logic [11:0] MCR_ADR_CAP     = 12'h179;
	localparam logic [11:0] MCR_ADR_GSTAT   = 12'h17a;
	localparam logic [11:0] MCR_ADR_GEN     = 12'h17b;
	localparam logic [11:0] MCR_ADR_BANK0   = 12'h400;
	localparam logic [11:0] MCR_ADR_LTYPE   = 12'h001;
	localparam logic [11:0] MCR_ADR_LADDR   = 12'h000;
	localparam logic [11:0] MCR_ADR_EXT0    = 12'h180;

	localparam int          MCR_CAP_GEN_P   = 8;
	localparam int          MCR_CAP_EXT_P   = 9;
	localparam int          MCR_CAP_CNT_P   = 10;
	localparam int          MCR_CAP_TES_P   = 11;
	localparam int          MCR_CAP_EXTCNT  = 16;
	localparam logic [7:0]  MCR_EXT_COUNT   = 8'h00;

	localparam int          MCR_GS_RESTART  = 0;
	localparam int          MCR_GS_ERRPTR   = 1;
	localparam int          MCR_GS_INPROG   = 2;

	localparam int          MCR_ST_PRESENT  = 63;
	localparam int          MCR_ST_OVER     = 62;
	localparam int          MCR_ST_NOTCORR  = 61;
	localparam int          MCR_ST_ENABLED  = 60;
	localparam int          MCR_ST_CNT_LO   = 38;
	localparam int          MCR_ST_CNT_HI   = 52;
	localparam int          MCR_ST_COL_LO   = 53;

	localparam logic [63:0] MCR_CTL_IMPL    = 64'h0000_0000_ffff_ffff;
	localparam logic [63:0] MCR_CTL_RESET   = 64'h0000_0000_0000_0000;
	localparam logic [63:0] MCR_GEN_RESET   = 64'h0000_0000_0000_0000;
	localparam logic [63:0] MCR_ZERO        = 64'h0000_0000_0000_0000;
	localparam logic [63:0] MCR_ONES        = 64'hffff_ffff_ffff_ffff;
	localparam logic [1:0]  MCR_LT_PARITY   = 2'h1;
	localparam logic [1:0]  MCR_LT_BUSFAIL  = 2'h2;

	typedef struct packed {
		logic        valid;
		logic [1:0]  bank;
		logic [5:0]  source;
		logic        corrected;
		logic [1:0]  color;
		logic [15:0] code;
		logic        restart_ok;
		logic        ptr_ok;
	} mcr_err_s;

	typedef struct packed {
		logic        valid;
		logic        bus_fail;
		logic [31:0] addr;
	} mcr_legacy_s;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [11:0] addr;
		logic [63:0] wdata;
	} mcr_req_s;

	function automatic logic [63:0] mcr_cap_word(input logic gen_p, input logic ext_p,
		input logic cnt_p, input logic tes_p);
		mcr_cap_word = MCR_ZERO;
		mcr_cap_word[7:0] = 8'(MCR_BANKS);
		mcr_cap_word[MCR_CAP_GEN_P] = gen_p;
		mcr_cap_word[MCR_CAP_EXT_P] = ext_p;
		mcr_cap_word[MCR_CAP_CNT_P] = cnt_p;
		mcr_cap_word[MCR_CAP_TES_P] = tes_p;
		mcr_cap_word[MCR_CAP_EXTCNT +: 8] = MCR_EXT_COUNT;
	endfunction

endpackage

// ### design/mcr_bank.sv
/*
 * One error-reporting bank: control enables, status logging with overwrite
 * priority and corrected-error counting.
 * Assumes register writes are already decoded by the parent.
 */
`timescale 1ns/1ps
module mcr_bank
	import mcr_pkg::*;
#(
	parameter bit CNT_P = 1'b1,
	parameter bit TES_P = 1'b1
)
(
	input  wire logic            clk_sys,
	input  wire logic            rst_n,
	input  wire logic            ctl_we,
	input  wire logic            sts_we,
	input  wire logic            strict_ctl,
	input  wire logic [63:0]     wdata,
	input  wire mcr_pkg::mcr_err_s err,
	output logic      [63:0]     ctl_reg,
	output logic      [63:0]     sts_reg,
	output logic                 fire
);

	logic        en_bit;
	logic        new_uc;
	logic        old_uc;
	logic        take_new;
	logic [14:0] cnt;

	assign en_bit = ctl_reg[err.source];
	assign new_uc = !err.corrected;
	assign old_uc = sts_reg[MCR_ST_NOTCORR];
	assign cnt    = sts_reg[MCR_ST_CNT_HI:MCR_ST_CNT_LO];

	always_comb
	begin
		if (!sts_reg[MCR_ST_PRESENT])
			take_new = 1'b1;
		else if (old_uc)
			take_new = 1'b0;
		else if (new_uc)
			take_new = 1'b1;
		else if (!sts_reg[MCR_ST_ENABLED] && en_bit)
			take_new = 1'b1;
		else
			take_new = !(sts_reg[MCR_ST_COL_LO +: 2] == 2'h2 && err.color != 2'h2);
	end

	// Control: only implemented flags move, legacy mode takes all-ones/zeros
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			ctl_reg <= MCR_CTL_RESET;
		else if (ctl_we && (!strict_ctl || wdata == MCR_ONES || wdata == MCR_ZERO))
			ctl_reg <= wdata & MCR_CTL_IMPL;
	end

	// Status: hardware set beats software clear
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			sts_reg <= MCR_ZERO;
		else if (err.valid)
		begin
			if (take_new)
			begin
				sts_reg[15:0] <= err.code;
				sts_reg[MCR_ST_NOTCORR] <= new_uc;
				sts_reg[MCR_ST_ENABLED] <= en_bit;
				if (TES_P)
					sts_reg[MCR_ST_COL_LO +: 2] <= new_uc ? 2'h0 : err.color;
			end
			sts_reg[MCR_ST_PRESENT] <= 1'b1;
			sts_reg[MCR_ST_OVER] <= sts_reg[MCR_ST_OVER] | sts_reg[MCR_ST_PRESENT];
			if (CNT_P && err.corrected && !sts_we)
			begin
				sts_reg[MCR_ST_CNT_HI - 1:MCR_ST_CNT_LO] <= 14'(cnt[13:0] + 14'h1);
				sts_reg[MCR_ST_CNT_HI] <= cnt[14] | (&cnt[13:0]);
			end
		end
		else if (sts_we && wdata == MCR_ZERO)
			sts_reg <= MCR_ZERO;
	end

	// Exception request for enabled, uncorrected errors
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			fire <= 1'b0;
		else
			fire <= err.valid && en_bit && new_uc;
	end

endmodule

// ### design/mcr_legacy.sv
/*
 * Legacy two-register capture: error type and address of the latest error.
 * Assumes one-cycle error pulses from the bus unit.
 */
`timescale 1ns/1ps
module mcr_legacy
	import mcr_pkg::*;
(
	input  wire logic               clk_sys,
	input  wire logic               rst_n,
	input  wire mcr_pkg::mcr_legacy_s lerr,
	input  wire logic               rd_type,
	output logic      [1:0]         type_reg,
	output logic      [31:0]        addr_reg,
	output logic                    fire
);

	// Capture, then raise the exception one cycle later
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			type_reg <= 2'h0;
			addr_reg <= 32'h0;
		end
		else if (lerr.valid)
		begin
			type_reg <= lerr.bus_fail ? MCR_LT_BUSFAIL : MCR_LT_PARITY;
			addr_reg <= lerr.addr;
		end
		else if (rd_type)
			type_reg <= 2'h0;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			fire <= 1'b0;
		else
			fire <= lerr.valid;
	end

endmodule

// ### dv/mcr_top_checker.sv
/* Port checker for mcr_top.
 * Bound to every mcr_top instance; sees its ports only. */
`timescale 1ns/1ps
module mcr_top_checker
	import mcr_pkg::*;
#(
	parameter bit GEN_P = 1'b1,
	parameter bit EXT_P = 1'b0,
	parameter bit CNT_P = 1'b1,
	parameter bit TES_P = 1'b1
)
(
	input wire logic                 clk_sys,
	input wire logic                 rstn,
	input wire mcr_pkg::mcr_req_s    req,
	input wire mcr_pkg::mcr_err_s    err,
	input wire mcr_pkg::mcr_legacy_s lerr,
	input wire logic [63:0]          rdata,
	input wire logic                 rvalid,
	input wire logic                 gp_fault,
	input wire logic                 check_exception,
	input wire logic                 shutdown
);
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	wire stat_wr = req.wr && req.addr[11:4] == 8'h40 && req.addr[1:0] == 2'h1;

	rd_answer_a:
	assert property (req.rd |=> rvalid) else $error("read not answered");
	rd_cause_a:
	assert property (rvalid |-> $past(req.rd)) else $error("answer without read");
	rd_idle_a:
	assert property (!req.rd |=> rdata == MCR_ZERO) else $error("data without read");
	cap_fields_a:
	assert property (req.rd && req.addr == MCR_ADR_CAP |=> rdata[23:0] ==
		{MCR_EXT_COUNT, 4'h0, TES_P, CNT_P, EXT_P, GEN_P, 8'(MCR_BANKS)})
		else $error("capability fields wrong");
	gp_fault_a:
	assert property (stat_wr && req.wdata != MCR_ZERO |=> gp_fault) else $error("no fault");
	gp_cause_a:
	assert property (gp_fault |-> $past(stat_wr && req.wdata != MCR_ZERO))
		else $error("fault without cause");
	legacy_exc_a:
	assert property (lerr.valid |-> ##2 (check_exception || shutdown))
		else $error("legacy error without exception");
	exc_cause_a:
	assert property (check_exception |-> $past(err.valid, 2) || $past(lerr.valid, 2))
		else $error("exception without error");
	shut_hold_a:
	assert property (shutdown |=> shutdown) else $error("shutdown dropped");

	cover property (check_exception);
	cover property (gp_fault);
	cover property (shutdown);
endmodule

bind mcr_top mcr_top_checker #(.GEN_P(GEN_P), .EXT_P(EXT_P), .CNT_P(CNT_P), .TES_P(TES_P))
	u_chk (.clk_sys(clk_sys), .rstn(rstn), .req(req), .err(err), .lerr(lerr),
	.rdata(rdata), .rvalid(rvalid), .gp_fault(gp_fault),
	.check_exception(check_exception), .shutdown(shutdown));

// ### dv/mcr_err_src.sv
/* Reporting units: post bank and legacy error pulses.
 * Called by the bench; drives on falling edges. */
`timescale 1ns/1ps
module mcr_err_src
	import mcr_pkg::*;
(
	input  wire logic            clk_sys,
	output mcr_pkg::mcr_err_s    err,
	output mcr_pkg::mcr_legacy_s lerr
);
	initial
	begin
		err = '0;
		lerr = '0;
	end
	task automatic post(input mcr_err_s e);
	begin
		@(negedge clk_sys);
		e.valid = 1'b1;
		err = e;
		@(negedge clk_sys);
		e = ~e;
		e.valid = 1'b0;
		err = e;
	end
	endtask
	task automatic legacy(input logic bf, input logic [31:0] a);
		mcr_legacy_s l;
	begin
		l = {1'b1, bf, a};
		@(negedge clk_sys);
		lerr = l;
		@(negedge clk_sys);
		l = ~l;
		l.valid = 1'b0;
		lerr = l;
	end
	endtask
endmodule

// ### dv/machine_check_registers_tb_top.sv
/* Bench for mcr_top: register port, bank logging, legacy capture.
 * Uses mcr_err_src as the reporting units. */
`timescale 1ns/1ps
module machine_check_registers_tb_top;
	import mcr_pkg::*;
	logic        clk_sys;
	logic        rstn;
	logic        strict_ctl;
	logic        g;
	logic        rvalid, gp_fault, check_exception, shutdown;
	logic [63:0] rdata, d, w;
	logic [31:0] a;
	mcr_req_s    req;
	mcr_err_s    err, e;
	mcr_legacy_s lerr;
	int          num_errors = 0;
	int          checks_done = 0;
	localparam logic [63:0] MUC = 64'hf000_0000_0000_ffff;
	localparam logic [63:0] MCO = 64'hf07f_ffc0_0000_ffff;

	mcr_top DUT (.clk_sys(clk_sys), .rstn(rstn), .req(req), .strict_ctl(strict_ctl),
		.err(err), .lerr(lerr), .rdata(rdata), .rvalid(rvalid), .gp_fault(gp_fault),
		.check_exception(check_exception), .shutdown(shutdown));
	mcr_err_src u_src (.clk_sys(clk_sys), .err(err), .lerr(lerr));

	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	function automatic logic [11:0] ca(input int b);
		return MCR_ADR_BANK0 + 12'(4 * b);
	endfunction
	function automatic logic [63:0] xs(input mcr_err_s e, input logic [14:0] n, input logic ov);
		xs = MCR_ZERO;
		xs[63:60] = {1'b1, ov, ~e.corrected, 1'b1};
		xs[54:53] = e.color;
		xs[52:38] = n;
		xs[15:0] = e.code;
	endfunction
	task automatic chk(input string s, input logic [63:0] x, input logic [63:0] v);
	begin
		checks_done++;
		if (v !== x)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", s, x, v);
		end
	end
	endtask
	task automatic rd(input logic [11:0] ad, output logic [63:0] q);
	begin
		@(negedge clk_sys);
		req.rd = 1'b1;
		req.addr = ad;
		@(negedge clk_sys);
		req.rd = 1'b0;
		q = rdata;
		chk("rvalid", 64'h1, {63'h0, rvalid});
	end
	endtask
	task automatic wr(input logic [11:0] ad, input logic [63:0] v);
	begin
		@(negedge clk_sys);
		req.wr = 1'b1;
		req.addr = ad;
		req.wdata = v;
		@(negedge clk_sys);
		req.wr = 1'b0;
		req.wdata = ~v;
		g = gp_fault;
	end
	endtask
	task automatic exc(input logic x);
	begin
		@(negedge clk_sys);
		chk("exception", {63'h0, x}, {63'h0, check_exception});
	end
	endtask
	task automatic final_report;
	begin
		$display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask

	initial
	begin
		#(25 * 5000);
		num_errors++;
		final_report();
	end

	initial
	begin
		void'($urandom(44586));
		rstn = 1'b0;
		strict_ctl = 1'b0;
		req = '0;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		rstn = 1'b1;
		repeat (3) @(negedge clk_sys);
		wr(MCR_ADR_CAP, {$urandom, $urandom});
		rd(MCR_ADR_CAP, d);
		chk("capability", {40'h0, MCR_EXT_COUNT, 8'h0d, 8'(MCR_BANKS)}, d);
		rd(MCR_ADR_GEN, d);
		chk("enable reset", MCR_GEN_RESET, d);
		wr(MCR_ADR_GEN, 64'h0000_ffff_0000_ffff);
		rd(MCR_ADR_GEN, d);
		chk("enable partial", MCR_GEN_RESET, d);
		wr(MCR_ADR_GEN, MCR_ONES);
		rd(MCR_ADR_GEN, d);
		chk("enable ones", MCR_ONES, d);
		for (int i = 0; i < MCR_BANKS; i++)
		begin
			strict_ctl = 1'b0;
			w = {$urandom, $urandom};
			wr(ca(i), w);
			rd(ca(i), d);
			chk("control", w & MCR_CTL_IMPL, d);
			strict_ctl = 1'b1;
			wr(ca(i), (i == 0) ? w : {$urandom, $urandom});
			rd(ca(i), d);
			chk("control strict", w & MCR_CTL_IMPL, d);
			wr(ca(i), (i == 3) ? MCR_ZERO : MCR_ONES);
			rd(ca(i), d);
			chk("control full", (i == 3) ? MCR_ZERO : MCR_CTL_IMPL, d);
		end
		wr(ca(2) + 12'h1, 64'h1);
		chk("fault", 64'h1, {63'h0, g});
		wr(ca(2) + 12'h1, MCR_ZERO);
		chk("no fault", 64'h0, {63'h0, g});
		e = mcr_err_s'(30'($urandom));
		e.bank = 2'h0;
		e.source = 6'($urandom_range(31));
		e.corrected = 1'b0;
		u_src.post(e);
		exc(1'b1);
		rd(MCR_ADR_GSTAT, d);
		chk("global", {61'h0, 1'b1, e.ptr_ok, e.restart_ok}, d & 64'h7);
		rd(ca(0) + 12'h1, d);
		chk("status uc", xs(e, 15'h0, 1'b0) & MUC, d & MUC);
		wr(MCR_ADR_GSTAT, MCR_ZERO);
		e.bank = 2'h1;
		e.corrected = 1'b1;
		e.color = 2'($urandom_range(2));
		u_src.post(e);
		exc(1'b0);
		rd(ca(1) + 12'h1, d);
		chk("status co", xs(e, 15'h1, 1'b0) & MCO, d & MCO);
		u_src.post(e);
		rd(ca(1) + 12'h1, d);
		chk("status over", xs(e, 15'h2, 1'b1) & MCO, d & MCO);
		wr(ca(1) + 12'h1, MCR_ZERO);
		rd(ca(1) + 12'h1, d);
		chk("status clear", MCR_ZERO, d);
		e.bank = 2'h3;
		e.corrected = 1'b0;
		u_src.post(e);
		exc(1'b0);
		for (int k = 0; k < 2; k++)
		begin
			a = $urandom;
			u_src.legacy(k[0], a);
			exc(1'b1);
			rd(MCR_ADR_LTYPE, d);
			chk("legacy type", {62'h0, k ? MCR_LT_BUSFAIL : MCR_LT_PARITY}, d);
			rd(MCR_ADR_LADDR, d);
			chk("legacy addr", {32'h0, a}, d);
			wr(MCR_ADR_GSTAT, MCR_ZERO);
		end
		wr(MCR_ADR_GSTAT, 64'h4);
		e.bank = 2'h2;
		u_src.post(e);
		repeat (3) @(negedge clk_sys);
		chk("shutdown", 64'h1, {63'h0, shutdown});
		final_report();
	end
endmodule
